/* File: ssst_top.sv */
// source selection, generator hand-over and indicator logic
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Overview of operation
// - boot walks four leds, versions, power on
// - usb led dark unless transfer active
// - sdi led lit on valid selected input
// - setting picks coax or optical input
// - data led on traffic, blinks when addressed
// - board status led lit after boot, latches once link ok
// - coax diag led: selected and valid only
// - optical diag led: selected and valid only
// - done led from the first clock after reset
// - outputs enabled after boot, input or generator
// - gray for hold seconds outside reference-only, then stored image
// - sdi led implies passthrough outside reference-only, generator idle
// - hd and 3g rates are valid
// - coax on after boot, optical mirrors it when fitted
// - generator frame size follows active format
// - image select follows active format
// - hold accepts 0 to 7 seconds
// - reference-only always sends generator picture
// - gpo off, high on valid, or high on absent
module ssst_top import ssst_pkg::*; #(
	parameter int         MS_CYC_P = MS_CYC,
	parameter logic [3:0] MCU_VER  = 4'h1,
	parameter logic [3:0] FPGA_VER = 4'h1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        coax_lock,
	input  wire logic [1:0]  coax_rate,
	input  wire logic        opt_lock,
	input  wire logic [1:0]  opt_rate,
	input  wire logic        opt_fitted,
	input  wire logic        fmt_large,
	input  wire logic        usb_drive,
	input  wire logic        usb_xfer,
	input  wire logic        usb_pattern,
	input  wire logic        bus_active,
	input  wire logic        bus_addressed,
	input  wire logic        link_ok,
	output ssst_panel_type   panel_led,
	output ssst_board_type   board_led,
	output ssst_route_type   route,
	output logic             general_output_pin
);
	logic [CTRL_W-1:0] ctrl_q;       // software settings
	ssst_state_type    state_q;      // boot progress
	logic [16:0]       ms_cnt_q;     // cycles within a ms
	logic              ms_tick;      // one pulse per ms
	logic [9:0]        step_ms_q;    // ms within a boot step
	logic [2:0]        boot_idx_q;   // walk 0..3, versions 4..5
	logic              valid_now;    // selected input usable
	logic              valid_q;      // previous valid, for edges
	logic [2:0]        gray_left_q;  // whole gray seconds left
	logic [2:0]        gray_left_d;
	logic [9:0]        sec_ms_q;     // ms within a gray second
	logic [9:0]        sec_ms_d;
	logic [5:0]        blink_q;      // data led off time left
	logic              link_seen_q;  // sticky link indication
	logic              acc;          // apb access phase
	logic              running;      // boot finished
	logic              boot_done_q;  // first running cycle already seen

	// a line rate is usable for passthrough
	function automatic logic rate_ok(input logic [1:0] r);
		return (r == RATE_HD) || (r == RATE_3G);
	endfunction

	assign running = (state_q == ST_RUN);
	assign acc     = psel && penable;
	assign ms_tick = (ms_cnt_q == 17'(MS_CYC_P - 1));

	// only the chosen port is judged
	// lock alone is not enough, rate must fit
	always_comb begin
		if (ctrl_q[CTRL_SEL_BIT]) begin
			valid_now = opt_lock && rate_ok(opt_rate);
		end else begin
			valid_now = coax_lock && rate_ok(coax_rate);
		end
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (acc && !pready) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (paddr == REG_CTRL) begin
				prdata <= {25'h0, ctrl_q};
			end else if (paddr == REG_STATUS) begin
				prdata <= {26'h0, link_seen_q, (gray_left_q != 3'h0),
					(route.src == SRC_GEN), running, valid_q, ctrl_q[CTRL_SEL_BIT]};
			end else begin
				// unmapped: error answer, reads zero
				pslverr <= 1'b1;
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// settings written at the completing edge only
	// three bits hold exactly 0..7 seconds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
		end else if (acc && pready && pwrite && paddr == REG_CTRL) begin
			ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end

	// free-running millisecond prescaler
	// paces boot steps, gray seconds and the data blink
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= 17'h0;
		end else if (ms_tick) begin
			ms_cnt_q <= 17'h0;
		end else begin
			ms_cnt_q <= ms_cnt_q + 17'h1;
		end
	end

	// boot sequence: walk, two versions, run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_WALK;
			step_ms_q  <= 10'h0;
			boot_idx_q <= 3'h0;
		end else if (ms_tick && !running) begin
			step_ms_q <= step_ms_q + 10'h1;
			case (state_q)
				ST_WALK: begin
					if (step_ms_q == 10'(WALK_STEP_MS - 1)) begin
						step_ms_q  <= 10'h0;
						boot_idx_q <= boot_idx_q + 3'h1;
						if (boot_idx_q == 3'h3) begin
							state_q <= ST_VER;
						end
					end
				end
				ST_VER: begin
					if (step_ms_q == 10'(VER_SHOW_MS - 1)) begin
						step_ms_q  <= 10'h0;
						boot_idx_q <= boot_idx_q + 3'h1;
						if (boot_idx_q == 3'h5) begin
							state_q <= ST_RUN;
						end
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// gray timer next value
	always_comb begin
		gray_left_d = gray_left_q;
		sec_ms_d    = sec_ms_q;
		if (!running || valid_now) begin
			// a returning input cancels the gray phase
			gray_left_d = 3'h0;
			sec_ms_d    = 10'h0;
		end else if (valid_q || state_q != ST_RUN) begin
			gray_left_d = 3'h0;
		end else if (gray_left_q != 3'h0 && ms_tick) begin
			if (sec_ms_q == 10'(MS_PER_S - 1)) begin
				sec_ms_d    = 10'h0;
				gray_left_d = gray_left_q - 3'h1;
			end else begin
				sec_ms_d = sec_ms_q + 10'h1;
			end
		end
		// loss of input, or boot end with none, reloads
		if (running && !valid_now && (valid_q || !boot_done_q)) begin
			gray_left_d = ctrl_q[CTRL_HOLD_LSB +: 3];
			sec_ms_d    = 10'h0;
		end
	end

	// valid_q and boot_done_q give the edges that reload the hold

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gray_left_q <= 3'h0;
			sec_ms_q    <= 10'h0;
			valid_q     <= 1'b0;
			boot_done_q <= 1'b0;
		end else begin
			gray_left_q <= gray_left_d;
			sec_ms_q    <= sec_ms_d;
			valid_q     <= valid_now;
			boot_done_q <= running;
		end
	end

	// output routing, registered toward the serializers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= '0;
		end else begin
			// outputs stay off until boot completes
			route.coax_en <= running;
			route.opt_en  <= running && opt_fitted;
			if (valid_now && !ctrl_q[CTRL_REF_BIT]) begin
				route.src <= ctrl_q[CTRL_SEL_BIT] ? SRC_OPT : SRC_COAX;
			end else begin
				route.src <= SRC_GEN;
			end
			route.gray <= !ctrl_q[CTRL_REF_BIT] && (gray_left_d != 3'h0);
			// image store select tracks the same format
			route.img_large <= fmt_large;
			route.h_active  <= fmt_large ? H_LARGE : H_SMALL;
			route.v_active  <= fmt_large ? V_LARGE : V_SMALL;
		end
	end

	// data led off-pulse timer, restarted per addressed frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_q <= 6'h0;
		end else if (bus_addressed) begin
			blink_q <= 6'(BLINK_MS);
		end else if (ms_tick && blink_q != 6'h0) begin
			blink_q <= blink_q - 6'h1;
		end
	end

	// link indication never drops once seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_seen_q <= 1'b0;
		end else if (link_ok) begin
			link_seen_q <= 1'b1;
		end
	end

	// indicators and general output pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_led          <= '0;
			board_led          <= '0;
			general_output_pin <= 1'b0;
		end else begin
			if (state_q == ST_WALK) begin
				// one led at a time during the walk
				panel_led <= ssst_panel_type'(4'h8 >> boot_idx_q[1:0]);
			end else if (state_q == ST_VER) begin
				panel_led <= ssst_panel_type'(boot_idx_q[0] ? FPGA_VER : MCU_VER);
			end else begin
				panel_led.power <= 1'b1;
				// usb led only during a transfer
				panel_led.usb   <= usb_drive && usb_xfer && usb_pattern;
				panel_led.sdi   <= valid_now;
				// traffic lights it, addressed traffic blinks it
				panel_led.data  <= bus_active && (blink_q == 6'h0);
			end
			// status only after boot and a good link
			board_led.status  <= running && link_seen_q;
			board_led.coax    <= !ctrl_q[CTRL_SEL_BIT] && coax_lock && rate_ok(coax_rate);
			board_led.optical <= ctrl_q[CTRL_SEL_BIT] && opt_lock && rate_ok(opt_rate);
			board_led.done    <= 1'b1;
			// three pin modes, unused code reads as off
			case (ctrl_q[CTRL_GPO_LSB +: 2])
				GPO_VALID:  general_output_pin <= valid_now;
				GPO_ABSENT: general_output_pin <= !valid_now;
				default:    general_output_pin <= 1'b0;
			endcase
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// sdi led one cycle behind validity
	sdi_led_a: assert property (running && $past(running) |-> panel_led.sdi == $past(valid_now))
		else $error("sdi led does not follow input validity");
	// coax diag never lit with optical selected
	coax_diag_a: assert property (board_led.coax |-> !$past(ctrl_q[CTRL_SEL_BIT]))
		else $error("coax diag lit while unselected");
	// optical diag never lit with coax selected
	opt_diag_a: assert property (board_led.optical |-> $past(ctrl_q[CTRL_SEL_BIT]))
		else $error("optical diag lit while unselected");
	// power led stays on once running
	power_led_a: assert property (running ##1 running |=> panel_led.power [*3])
		else $error("power led dropped after boot");
	// usb led dark without a drive
	usb_dark_a: assert property (running && !usb_drive |=> !panel_led.usb)
		else $error("usb led lit without drive");
	// lit sdi led in normal mode means passthrough
	// boot patterns reuse the sdi led, so only run cycles count
	sdi_route_a: assert property ($past(running) && panel_led.sdi && !$past(ctrl_q[CTRL_REF_BIT])
		|-> route.src != SRC_GEN)
		else $error("sdi led lit while generator routed");
	// reference-only keeps the generator on air
	ref_only_a: assert property (ctrl_q[CTRL_REF_BIT] && $stable(ctrl_q) |=> route.src == SRC_GEN)
		else $error("input passed in reference-only mode");
	// loss with nonzero hold starts gray next cycle
	gray_start_a: assert property (running && $past(running) && valid_q && !valid_now
		&& ctrl_q[CTRL_HOLD_LSB +: 3] != 3'h0 && !ctrl_q[CTRL_REF_BIT] |=> route.gray && route.src == SRC_GEN)
		else $error("gray phase not started on input loss");
	// zero hold gives no gray at all
	no_gray_a: assert property (ctrl_q[CTRL_HOLD_LSB +: 3] == 3'h0 && $stable(ctrl_q) && gray_left_q == 3'h0
		|=> !route.gray)
		else $error("gray output with zero hold");
	opt_mirror_a: assert property (opt_fitted |=> route.opt_en == route.coax_en)
		else $error("optical output not mirroring coax");
	// absent mode drives inverse of validity
	gpo_mode_a: assert property (ctrl_q[CTRL_GPO_LSB +: 2] == GPO_ABSENT |=> general_output_pin == !$past(valid_now))
		else $error("gpo wrong in absent mode");
	out_boot_a: assert property (!running |=> !route.coax_en)
		else $error("output enabled before boot end");
endmodule

/* File: ssst_pkg.sv */
// shared constants and types for the sdi source select and status block
package ssst_pkg;
	// clock rate and derived millisecond count
	localparam int CLK_HZ       = 125_000_000;
	localparam int MS_PER_S     = 1000;
	localparam int MS_CYC       = CLK_HZ / MS_PER_S;
	// power-up indicator timing, in ms
	localparam int WALK_STEP_MS = 250;
	localparam int VER_SHOW_MS  = 1000;
	// data indicator off-pulse, in ms
	localparam int BLINK_MS     = 50;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// control field positions
	localparam int CTRL_SEL_BIT  = 0;
	localparam int CTRL_HOLD_LSB = 1;
	localparam int CTRL_REF_BIT  = 4;
	localparam int CTRL_GPO_LSB  = 5;
	localparam int CTRL_W        = 7;
	localparam logic [6:0] CTRL_RST = 7'h02;
	// line rate codes from the receivers
	localparam logic [1:0] RATE_HD = 2'h1;
	localparam logic [1:0] RATE_3G = 2'h2;
	// general output pin modes
	localparam logic [1:0] GPO_OFF    = 2'h0;
	localparam logic [1:0] GPO_VALID  = 2'h1;
	localparam logic [1:0] GPO_ABSENT = 2'h2;
	// output source codes
	localparam logic [1:0] SRC_COAX = 2'h0;
	localparam logic [1:0] SRC_OPT  = 2'h1;
	localparam logic [1:0] SRC_GEN  = 2'h2;
	// generator frame sizes
	localparam logic [11:0] H_SMALL = 12'h500;
	localparam logic [10:0] V_SMALL = 11'h2d0;
	localparam logic [11:0] H_LARGE = 12'h780;
	localparam logic [10:0] V_LARGE = 11'h438;

	typedef enum logic [1:0] {ST_WALK, ST_VER, ST_RUN} ssst_state_type;

	// front-panel indicators
	typedef struct packed {
		logic power;
		logic usb;
		logic sdi;
		logic data;
	} ssst_panel_type;

	// board diagnostic indicators
	typedef struct packed {
		logic status;
		logic coax;
		logic optical;
		logic done;
	} ssst_board_type;

	// output routing to the serializers
	typedef struct packed {
		logic        coax_en;
		logic        opt_en;
		logic [1:0]  src;
		logic        gray;
		logic        img_large;
		logic [11:0] h_active;
		logic [10:0] v_active;
	} ssst_route_type;
endpackage

/* File: ssst_src_model.sv */
// upstream sdi source model: receiver lock and rate
`timescale 1ns/1ns
module ssst_src_model (
	input  wire logic       pclk,
	input  wire logic       coax_on,
	input  wire logic       opt_on,
	input  wire logic [1:0] rate_sel,
	output logic            coax_lock,
	output logic [1:0]      coax_rate,
	output logic            opt_lock,
	output logic [1:0]      opt_rate
);
	logic [1:0] junk_q = 2'h0; // wandering code on a dead link
	// stale rate moves each cycle, passing through the hd and 3g codes too
	always_ff @(posedge pclk) begin
		junk_q <= junk_q + 2'h1;
	end
	// rate_sel code, whatever it is, while locked
	assign coax_lock = coax_on;
	assign coax_rate = coax_on ? rate_sel : junk_q;
	assign opt_lock  = opt_on;
	assign opt_rate  = opt_on ? rate_sel : ~junk_q;
endmodule

/* File: ssst_top_tb.sv */
// self-checking bench for source select, generator and indicators
`timescale 1ns/1ns
// compare, count, report
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t %h %h", $time, a, b); end end
module ssst_top_tb import ssst_pkg::*; ;
	localparam int  MSC = 10;       // short ms keeps boot near 30k cycles
	logic           pclk = 1'b0;
	logic           presetn = 1'b0;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [7:0]     paddr = 8'h00;
	logic [31:0]    pwdata = 32'h0;
	logic           coax_on = 1'b0; // source present
	logic           opt_on = 1'b0;
	logic [1:0]     rate_sel = RATE_HD;
	logic           opt_fitted = 1'b1;
	logic           fmt_large = 1'b0;
	logic           usb_drive = 1'b0;
	logic           usb_xfer = 1'b0;
	logic           usb_pattern = 1'b0;
	logic           bus_active = 1'b0;
	logic           bus_addressed = 1'b0;
	logic           link_ok = 1'b0;
	logic [31:0]    prdata;
	logic           pready, pslverr, coax_lock, opt_lock, general_output_pin;
	logic [1:0]     coax_rate, opt_rate;
	ssst_panel_type panel_led;
	ssst_board_type board_led;
	ssst_route_type route;
	int             mismatches = 0;
	int             samples_checked = 0;
	// block under test
	ssst_top #(.MS_CYC_P(MSC)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .coax_lock, .coax_rate, .opt_lock, .opt_rate, .opt_fitted, .fmt_large, .usb_drive, .usb_xfer,
		.usb_pattern, .bus_active, .bus_addressed, .link_ok, .panel_led, .board_led, .route, .general_output_pin);
	// far-side source
	ssst_src_model src_u (.pclk, .coax_on, .opt_on, .rate_sel, .coax_lock, .coax_rate, .opt_lock, .opt_rate);
	// 8 ns clock
	initial begin
		forever #4 pclk = ~pclk;
	end
	// wait n edges, then let updates land
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	// one apb transfer held until pready
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] erd,
		input logic eerr);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!wr) `CHK(prdata, erd)
		`CHK(pslverr, eerr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reset, boot sequence, idle generator
	task automatic t_boot();
		int i;
		tick(4);
		`CHK({panel_led, board_led, route}, 37'h0)
		@(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		`CHK({panel_led, board_led.done}, 5'h11)
		acc(1'b0, REG_CTRL, 32'h0, 32'h2, 1'b0);
		acc(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
		acc(1'b1, REG_STATUS, 32'hff, 32'h0, 1'b0);
		@(posedge pclk);
		link_ok <= 1'b1;
		tick(1);
		`CHK(route.coax_en, 1'b0)
		for (i = 0; i < 40000 && route.coax_en !== 1'b1; i++) tick(1);
		`CHK(i > 29900 && i < 30050, 1'b1)
		`CHK({panel_led, board_led}, 8'h89)
		`CHK({route.coax_en, route.opt_en, route.src, route.gray}, {2'h3, SRC_GEN, 1'b1})
		`CHK({route.h_active, route.v_active}, {H_SMALL, V_SMALL})
	endtask
	// passthrough, rate codes, optical fit
	task automatic t_pass();
		acc(1'b1, REG_CTRL, 32'h22, 32'h0, 1'b0);
		@(posedge pclk);
		coax_on <= 1'b1;
		opt_on <= 1'b1;
		tick(2);
		`CHK({route.src, panel_led.sdi}, {SRC_COAX, 1'b1})
		`CHK({board_led.coax, board_led.optical}, 2'h2)
		`CHK({route.gray, general_output_pin}, 2'h1)
		@(posedge pclk);
		rate_sel <= 2'h3;
		opt_fitted <= 1'b0;
		tick(2);
		`CHK({route.src, panel_led.sdi}, {SRC_GEN, 1'b0})
		`CHK({route.coax_en, route.opt_en}, 2'h2)
		@(posedge pclk);
		rate_sel <= RATE_3G;
		tick(2);
		`CHK({route.src, panel_led.sdi}, {SRC_COAX, 1'b1})
	endtask
	// gray hold, restart, cancel, format, gpo absent
	task automatic t_gray();
		@(posedge pclk);
		coax_on <= 1'b0;
		tick(2);
		`CHK({route.src, route.gray}, {SRC_GEN, 1'b1})
		tick(500 * MSC);
		@(posedge pclk);
		coax_on <= 1'b1;
		tick(2);
		`CHK({route.src, route.gray}, {SRC_COAX, 1'b0})
		@(posedge pclk);
		coax_on <= 1'b0;
		tick(1000 * MSC - 20);
		`CHK(route.gray, 1'b1)
		tick(40);
		`CHK({route.src, route.gray}, {SRC_GEN, 1'b0})
		@(posedge pclk);
		fmt_large <= 1'b1;
		tick(2);
		`CHK({route.img_large, route.h_active, route.v_active}, {1'b1, H_LARGE, V_LARGE})
		acc(1'b1, REG_CTRL, 32'h40, 32'h0, 1'b0);
		tick(1);
		`CHK(general_output_pin, 1'b1)
		@(posedge pclk);
		coax_on <= 1'b1;
		tick(2);
		`CHK(general_output_pin, 1'b0)
		@(posedge pclk);
		coax_on <= 1'b0;
		tick(2);
		`CHK({route.src, route.gray}, {SRC_GEN, 1'b0})
	endtask
	// optical select and reference-only
	task automatic t_opt();
		acc(1'b1, REG_CTRL, 32'h01, 32'h0, 1'b0);
		@(posedge pclk);
		coax_on <= 1'b1;
		opt_on <= 1'b0;
		tick(2);
		`CHK({route.src, board_led.coax}, {SRC_GEN, 1'b0})
		@(posedge pclk);
		opt_on <= 1'b1;
		tick(2);
		`CHK({route.src, board_led.optical, board_led.coax}, {SRC_OPT, 2'h2})
		`CHK(general_output_pin, 1'b0)
		acc(1'b1, REG_CTRL, 32'h11, 32'h0, 1'b0);
		tick(2);
		`CHK({route.src, panel_led.sdi}, {SRC_GEN, 1'b1})
		acc(1'b0, REG_STATUS, 32'h0, 32'h2f, 1'b0);
	endtask
	// usb and data indicators
	task automatic t_panel();
		@(posedge pclk);
		usb_drive <= 1'b1;
		usb_xfer <= 1'b1;
		usb_pattern <= 1'b1;
		bus_active <= 1'b1;
		link_ok <= 1'b0;
		tick(2);
		`CHK({panel_led.usb, panel_led.data}, 2'h3)
		@(posedge pclk);
		usb_xfer <= 1'b0;
		bus_addressed <= 1'b1;
		@(posedge pclk);
		bus_addressed <= 1'b0;
		tick(2);
		`CHK({panel_led.usb, panel_led.data}, 2'h0)
		tick(50 * MSC + 20);
		`CHK(panel_led.data, 1'b1)
		`CHK(board_led.status, 1'b1)
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		t_boot();
		t_pass();
		t_gray();
		t_opt();
		t_panel();
		test_done();
	end
	// watchdog: boot 30k plus scenarios near 16k cycles
	initial begin
		repeat (80000) @(posedge pclk);
		mismatches++;
		test_done();
	end
endmodule
